// >>> hdl/stdm_top.sv
// Serial TDM slot, address mask and protocol byte block, two channels.
// Assumes an AHB-Lite master on the core clock and slow link pins.
//
// Overview of operation
// - Sync every 128 input clocks by default.
// - Period bit set gives 256 input clocks.
// - Clock source set counts output clocks.
// - Mode clear: data enable pin not driven.
// - Mode set: data enable pin driven.
// - Slot bit 0 drives sync; bits select slots.
// - Slot bit 0 clear follows outside sync.
// - Address mask: receive high, transmit low byte.
// - Protocol write keeps only low byte.
// - Protocol read: received byte high, zero low.
// - Channel two slot register matches one.
// - Channel two address mask matches one.
// - Channel two protocol register matches one.
// - Load strobes every sixteen selected clocks.
// - Slot, mask, control registers read zero.
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "stdm_defs.svh"

module stdm_top #(
  parameter int NCH = 2,    // Number of serial channels.
  parameter int ADDR_W = 8  // Bus address bits decoded.
) (
  input wire logic i_core_clk,                   // Core clock, 20 MHz.
  input wire logic i_nrst,                       // Synchronous reset, active low.
  input wire logic i_hsel,                       // Slave select.
  input wire logic [ADDR_W-1:0] i_haddr,         // Byte address.
  input wire logic [1:0] i_htrans,               // Transfer type.
  input wire logic i_hwrite,                     // High for a write.
  input wire logic [2:0] i_hsize,                // Transfer size.
  input wire logic i_hready,                     // Bus ready.
  input wire logic [31:0] i_hwdata,              // Write data.
  output logic [31:0] o_hrdata,                  // Read data.
  output logic o_hreadyout,                      // Slave ready.
  output logic o_hresp,                          // Response, always OKAY.
  input wire logic i_link_clk,                   // Link clock.
  input wire logic [NCH-1:0] i_input_bit_clock,  // Input bit clocks.
  input wire logic [NCH-1:0] i_output_bit_clock, // Output bit clocks.
  input wire logic [NCH-1:0] i_frame_sync_pin,   // Frame sync pin level.
  output logic [NCH-1:0] o_frame_sync_pin,       // Frame sync drive value.
  output logic [NCH-1:0] o_frame_sync_pin_oe,    // Frame sync drive enable.
  output logic [NCH-1:0] o_data_out_enable_pin,  // Data enable drive value.
  output logic [NCH-1:0] o_data_out_enable_pin_oe, // Data enable drive enable.
  output logic [NCH-1:0] o_input_load_strobe,    // Input word load strobe.
  output logic [NCH-1:0] o_output_load_strobe,   // Output word load strobe.
  input wire logic [NCH-1:0] i_rx_word_strobe,   // Rising edge marks a word.
  input wire logic [NCH*3-1:0] i_rx_addr,        // Address with the word.
  input wire logic [NCH*8-1:0] i_rx_protocol,    // Protocol byte received.
  output logic [NCH*8-1:0] o_tx_addr_mask,       // Transmit address mask.
  output logic [NCH*8-1:0] o_tx_protocol         // Protocol byte to send.
);

  // ----------------
  // Bus slave: address phase capture and data phase state.
  // ----------------
  localparam int CH_W = ADDR_W - `STDM_CH_SHIFT; // Channel field width.

  stdm_pkg::stdm_phase_e ph_reg;     // Data phase in progress.
  stdm_pkg::stdm_phase_e ph_next;    // Next data phase.
  logic [CH_W-1:0] wr_ch_reg;        // Channel of the pending write.
  logic [1:0] wr_idx_reg;            // Register of the pending write.
  logic [CH_W-1:0] a_ch;             // Channel field of the address.
  logic [1:0] a_idx;                 // Register field of the address.
  logic a_take;                      // Address phase taken this edge.
  logic a_map;                       // Address hits a register.
  logic [31:0] rdata_next;           // Read data for the coming phase.
  logic [7:0] rx_byte [NCH];         // Received bytes, one per channel.

  // Decode the address phase.
  always_comb begin
    a_ch = i_haddr[ADDR_W-1:`STDM_CH_SHIFT];
    a_idx = i_haddr[`STDM_CH_SHIFT-1:`STDM_REG_SHIFT];
    a_take = i_hsel && i_htrans[1] && i_hready;
    a_map = (a_ch < CH_W'(NCH)) && (i_haddr[1:0] == 2'b00);
  end

  // A write is kept only for a mapped, whole-word transfer.
  always_comb begin
    ph_next = stdm_pkg::PH_IDLE;
    if (a_take && i_hwrite && a_map && (i_hsize == 3'b010)) begin
      ph_next = stdm_pkg::PH_WRITE;
    end
  end

  // Read data: only the protocol register answers, all else reads zero.
  always_comb begin
    rdata_next = 32'h0000_0000;
    for (int c = 0; c < NCH; c++) begin
      if (a_take && !i_hwrite && a_map && (a_ch == CH_W'(c)) &&
          (a_idx == `STDM_IDX_PROTO)) begin
        rdata_next = {16'h0000, rx_byte[c], 8'h00};
      end
    end
  end

  // The data phase state follows every taken address phase.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      ph_reg <= stdm_pkg::PH_IDLE;
      wr_ch_reg <= '0;
      wr_idx_reg <= 2'h0;
    end else if (i_hready) begin
      ph_reg <= ph_next;
      wr_ch_reg <= a_ch;
      wr_idx_reg <= a_idx;
    end
  end

  // Read data is registered so it stands for the whole data phase.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (i_hready) begin
      o_hrdata <= rdata_next;
    end
  end

  // The slave never inserts wait states and never reports an error.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  // ----------------
  // Link domain reset, released a few link cycles after the core reset.
  // ----------------
  logic lrst_meta_reg; // First stage, read only by the second.
  logic link_nrst;     // Reset for all link logic.

  // Carry the reset level into the link domain.
  always_ff @(posedge i_link_clk) begin
    lrst_meta_reg <= i_nrst;
    link_nrst <= lrst_meta_reg;
  end

  // ----------------
  // Per channel logic; both channels share one layout.
  // ----------------
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    stdm_pkg::stdm_slot_t slot_reg;   // Slot configuration.
    stdm_pkg::stdm_addr_t addr_reg;   // Receive and transmit masks.
    stdm_pkg::stdm_byte_t proto_reg;  // Outgoing protocol byte.
    logic [2:0] ctrl_reg;             // Clock source and strobe enables.
    stdm_pkg::stdm_byte_t rx_reg;     // Last accepted protocol byte.
    logic wr_hit;                     // Pending write targets this channel.
    logic tog_core;                   // Receive toggle in core domain.
    logic tog_core_d;                 // Delayed copy for edge detection.
    stdm_pkg::stdm_slot_t slot_s;     // Slot configuration, link side.
    stdm_pkg::stdm_addr_t addr_s;     // Masks, link side.
    stdm_pkg::stdm_byte_t proto_s;    // Outgoing byte, link side.
    logic [2:0] ctrl_s;               // Control, link side.
    logic ick_s;                      // Input bit clock, synchronised.
    logic ock_s;                      // Output bit clock, synchronised.
    logic fs_s;                       // Frame sync pin, synchronised.
    logic strobe_s;                   // Receive strobe, synchronised.
    logic [2:0] raddr_s;              // Receive address, synchronised.
    stdm_pkg::stdm_byte_t rproto_s;   // Receive byte, synchronised.
    logic sel_d;                      // Previous selected bit clock.
    logic fs_d;                       // Previous frame sync level.
    logic strobe_d;                   // Previous receive strobe.
    logic sel_clk;                    // Selected bit clock level.
    logic tick;                       // Selected bit clock rising edge.
    logic restart;                    // Outside sync rising edge.
    logic rx_accept;                  // Received word is for us.
    logic [7:0] count;                // Bit position in the frame.
    logic wrap;                       // Frame boundary tick.
    stdm_pkg::stdm_byte_t hold_reg;   // Accepted byte for the core.
    logic tog_link_reg;               // Flips once per accepted word.

    assign rx_byte[ch] = rx_reg;
    assign wr_hit = (ph_reg == stdm_pkg::PH_WRITE) && (wr_ch_reg == CH_W'(ch));

    // Software writes; none of these registers can be read back.
    always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
        slot_reg <= `STDM_RST_SLOT;
        addr_reg <= `STDM_RST_ADDR;
        proto_reg <= `STDM_RST_PROTO;
        ctrl_reg <= `STDM_RST_CTRL;
      end else if (wr_hit) begin
        unique case (wr_idx_reg)
          `STDM_IDX_SLOT: begin
            slot_reg <= i_hwdata[9:0];
          end
          `STDM_IDX_ADDR: begin
            addr_reg <= i_hwdata[15:0];
          end
          `STDM_IDX_PROTO: begin
            proto_reg <= i_hwdata[`STDM_PROTO_MSB:0];
          end
          `STDM_IDX_CTRL: begin
            ctrl_reg <= i_hwdata[2:0];
          end
        endcase
      end
    end

    // Configuration reaches the link as slow levels.
    stdm_sync #(.WIDTH(37)) u_cfg_sync (
      .i_clk(i_link_clk),
      .i_nrst(link_nrst),
      .i_async({slot_reg, addr_reg, proto_reg, ctrl_reg}),
      .o_sync({slot_s, addr_s, proto_s, ctrl_s})
    );

    // Pins are brought into the link domain before any use.
    stdm_sync #(.WIDTH(15)) u_pin_sync (
      .i_clk(i_link_clk),
      .i_nrst(link_nrst),
      .i_async({i_input_bit_clock[ch], i_output_bit_clock[ch], i_frame_sync_pin[ch],
                i_rx_word_strobe[ch], i_rx_addr[ch*3 +: 3], i_rx_protocol[ch*8 +: 8]}),
      .o_sync({ick_s, ock_s, fs_s, strobe_s, raddr_s, rproto_s})
    );

    // Choose the bit clock and find its edges and the outside sync edge.
    always_comb begin
      sel_clk = ctrl_s[`STDM_CTRL_CLKSRC_BIT] ? ock_s : ick_s;
      tick = sel_clk && !sel_d;
      restart = !slot_s[`STDM_SLOT_SYNC_BIT] && fs_s && !fs_d;
      rx_accept = strobe_s && !strobe_d &&
                  (!slot_s[`STDM_SLOT_MODE_BIT] ||
                   addr_s[`STDM_ADDR_RX_LSB + 32'(raddr_s)]);
    end

    // Clock and sync history resets high so a pin already high gives no edge; strobe history resets low.
    always_ff @(posedge i_link_clk) begin
      if (!link_nrst) begin
        sel_d <= 1'b1;
        fs_d <= 1'b1;
        strobe_d <= 1'b0;
      end else begin
        sel_d <= sel_clk;
        fs_d <= fs_s;
        strobe_d <= strobe_s;
      end
    end

    // Frame counter on the selected bit clock.
    stdm_frame_cnt u_frame (
      .i_clk(i_link_clk),
      .i_nrst(link_nrst),
      .i_tick(tick),
      .i_long(slot_s[`STDM_SLOT_SYNC_PERIOD_SEL_BIT]),
      .i_restart(restart),
      .o_count(count),
      .o_wrap(wrap)
    );

    // Frame sync: one bit clock high per frame start, low once passive.
    always_ff @(posedge i_link_clk) begin
      if (!link_nrst) begin
        o_frame_sync_pin[ch] <= 1'b0;
        o_frame_sync_pin_oe[ch] <= 1'b0;
      end else begin
        o_frame_sync_pin_oe[ch] <= slot_s[`STDM_SLOT_SYNC_BIT];
        if (tick || !slot_s[`STDM_SLOT_SYNC_BIT]) begin
          o_frame_sync_pin[ch] <= slot_s[`STDM_SLOT_SYNC_BIT] && wrap;
        end
      end
    end

    // Word load strobes mark each sixteen-bit word when enabled.
    always_ff @(posedge i_link_clk) begin
      if (!link_nrst) begin
        o_input_load_strobe[ch] <= 1'b0;
        o_output_load_strobe[ch] <= 1'b0;
      end else if (tick) begin
        o_input_load_strobe[ch] <= ctrl_s[`STDM_CTRL_ILOAD_BIT] &&
            (count[3:0] == 4'(`STDM_WORD_BITS - 1));
        o_output_load_strobe[ch] <= ctrl_s[`STDM_CTRL_OLOAD_BIT] &&
            (count[3:0] == 4'(`STDM_WORD_BITS - 1));
      end
    end

    // Data enable is driven only in multiprocessor mode, high in our slots.
    always_ff @(posedge i_link_clk) begin
      if (!link_nrst) begin
        o_data_out_enable_pin[ch] <= 1'b0;
        o_data_out_enable_pin_oe[ch] <= 1'b0;
      end else begin
        o_data_out_enable_pin_oe[ch] <= slot_s[`STDM_SLOT_MODE_BIT];
        o_data_out_enable_pin[ch] <= slot_s[`STDM_SLOT_MODE_BIT] && !count[7] &&
            slot_s[32'(count[6:4])];
      end
    end

    // Transmit address mask and protocol byte go out as held levels.
    always_ff @(posedge i_link_clk) begin
      if (!link_nrst) begin
        o_tx_addr_mask[ch*8 +: 8] <= 8'h00;
        o_tx_protocol[ch*8 +: 8] <= 8'h00;
      end else begin
        o_tx_addr_mask[ch*8 +: 8] <= addr_s[`STDM_ADDR_TX_MSB:0];
        o_tx_protocol[ch*8 +: 8] <= proto_s;
      end
    end

    // An accepted byte is held and announced by a toggle.
    always_ff @(posedge i_link_clk) begin
      if (!link_nrst) begin
        hold_reg <= 8'h00;
        tog_link_reg <= 1'b0;
      end else if (rx_accept) begin
        hold_reg <= rproto_s;
        tog_link_reg <= !tog_link_reg;
      end
    end

    // The toggle crosses back to the core clock.
    stdm_sync #(.WIDTH(1)) u_tog_sync (
      .i_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_async(tog_link_reg),
      .o_sync(tog_core)
    );

    // On each toggle edge the held byte is stable and is taken.
    always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
        tog_core_d <= 1'b0;
        rx_reg <= 8'h00;
      end else begin
        tog_core_d <= tog_core;
        if (tog_core != tog_core_d) begin
          rx_reg <= hold_reg;
        end
      end
    end
  end

endmodule

// >>> pkg/stdm_defs.svh
// Constants for the serial TDM and multiprocessor configuration block.
// Assumes inclusion by bare name from files that need offsets or fields.
`ifndef STDM_DEFS_SVH
`define STDM_DEFS_SVH

// ----------------
// Register map: one block of four words per channel.
// ----------------
`define STDM_CH_SHIFT 4
`define STDM_REG_SHIFT 2
`define STDM_IDX_SLOT 2'h0
`define STDM_IDX_ADDR 2'h1
`define STDM_IDX_PROTO 2'h2
`define STDM_IDX_CTRL 2'h3

// ----------------
// Field positions.
// ----------------
`define STDM_SLOT_SYNC_BIT 0
`define STDM_SLOT_MODE_BIT 8
`define STDM_SLOT_SYNC_PERIOD_SEL_BIT 9
`define STDM_ADDR_RX_LSB 8
`define STDM_ADDR_TX_MSB 7
`define STDM_PROTO_MSB 7
`define STDM_CTRL_CLKSRC_BIT 0
`define STDM_CTRL_ILOAD_BIT 1
`define STDM_CTRL_OLOAD_BIT 2

// ----------------
// Reset values and timing counts.
// ----------------
`define STDM_RST_SLOT 10'h000
`define STDM_RST_ADDR 16'h0000
`define STDM_RST_PROTO 8'h00
`define STDM_RST_CTRL 3'h0
`define STDM_FRAME_SHORT 128
`define STDM_FRAME_LONG 256
`define STDM_WORD_BITS 16

`endif

// >>> pkg/stdm_pkg.sv
// Types shared by the serial TDM configuration block.
// Assumes the constants header is compiled alongside.
package stdm_pkg;

  // Data phase state of the bus slave.
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b01,
    PH_WRITE = 2'b10
  } stdm_phase_e;

  typedef logic [9:0] stdm_slot_t;   // Slot register contents.
  typedef logic [15:0] stdm_addr_t;  // Address mask register contents.
  typedef logic [7:0] stdm_byte_t;   // Protocol byte.

endpackage

// >>> hdl/stdm_sync.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; words need their own stability rule.
`timescale 1ns/100ps

module stdm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,               // Destination clock.
  input wire logic i_nrst,              // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] i_async, // Level from the other domain.
  output logic [WIDTH-1:0] o_sync       // Level safe in this domain.
);

  logic [WIDTH-1:0] meta_reg; // First stage, read only by the second.

  // The second stage alone looks at the first one.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule

// >>> hdl/stdm_frame_cnt.sv
// Bit counter inside one frame of 128 or 256 bit clocks.
// Assumes i_tick is a one-cycle pulse per selected bit clock edge.
`timescale 1ns/100ps
`include "stdm_defs.svh"

module stdm_frame_cnt (
  input wire logic i_clk,       // Link clock.
  input wire logic i_nrst,      // Synchronous reset, active low.
  input wire logic i_tick,      // One pulse per bit clock period.
  input wire logic i_long,      // High selects the 256-clock frame.
  input wire logic i_restart,   // Realign to bit 0 on an outside sync.
  output logic [7:0] o_count,   // Bit position in the frame.
  output logic o_wrap           // Tick that ends the frame.
);

  logic [7:0] last_bit; // Last bit position of the frame.

  // Frame length picks the last position.
  always_comb begin
    last_bit = i_long ? 8'(`STDM_FRAME_LONG - 1) : 8'(`STDM_FRAME_SHORT - 1);
    o_wrap = i_tick && (o_count == last_bit);
  end

  // The counter steps on every tick and folds back after the last bit.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_count <= 8'h00;
    end else if (i_restart) begin
      o_count <= 8'h00;
    end else if (o_wrap) begin
      o_count <= 8'h00;
    end else if (i_tick) begin
      o_count <= o_count + 8'h01;
    end
  end

endmodule

// >>> verification/stdm_chk.sv
// Checker for the TDM slot block: bus reads and channel 0 link pins.
// Assumes it is bound into stdm_top and that bit clocks are slow.
`timescale 1ns/100ps
module stdm_chk #(
  parameter int NCH = 2, // Channels.
  parameter int ADDR_W = 8 // Address bits.
) (
  input wire logic i_core_clk, // Core clock.
  input wire logic i_nrst, // Reset, active low.
  input wire logic i_hsel, // Slave select.
  input wire logic [ADDR_W-1:0] i_haddr, // Byte address.
  input wire logic [1:0] i_htrans, // Transfer type.
  input wire logic i_hwrite, // Write.
  input wire logic i_hready, // Bus ready.
  input wire logic [31:0] o_hrdata, // Read data.
  input wire logic i_link_clk, // Link clock.
  input wire logic [NCH-1:0] o_frame_sync_pin, // Sync value.
  input wire logic [NCH-1:0] o_frame_sync_pin_oe, // Sync enable.
  input wire logic [NCH-1:0] o_data_out_enable_pin, // Data enable value.
  input wire logic [NCH-1:0] o_data_out_enable_pin_oe, // Data enable drive.
  input wire logic [NCH-1:0] o_input_load_strobe // Input strobe.
);
  logic [7:0] ld_gap; // Link cycles since the last strobe rise.
  logic [11:0] fs_gap; // Link cycles since the last sync rise.
  logic ld_q, fs_q, ld_seen, fs_seen; // Previous levels and first-rise flags.
  // Strobe gap counter; it saturates so a pause never wraps to a short gap.
  always_ff @(posedge i_link_clk) begin
    ld_q <= i_nrst & o_input_load_strobe[0];
    if (!i_nrst) begin
      ld_seen <= 1'b0;
      ld_gap <= 8'h00;
    end else if (o_input_load_strobe[0] && !ld_q) begin
      ld_seen <= 1'b1;
      ld_gap <= 8'h01;
    end else if (ld_gap != 8'hFF) begin
      ld_gap <= ld_gap + 8'h01;
    end
  end
  // Sync gap counter, built the same way.
  always_ff @(posedge i_link_clk) begin
    fs_q <= i_nrst & o_frame_sync_pin[0];
    if (!i_nrst) begin
      fs_seen <= 1'b0;
      fs_gap <= 12'h000;
    end else if (o_frame_sync_pin[0] && !fs_q) begin
      fs_seen <= 1'b1;
      fs_gap <= 12'h001;
    end else if (fs_gap != 12'hFFF) begin
      fs_gap <= fs_gap + 12'h001;
    end
  end
  chk_read_low_zero:
  assert property (@(posedge i_core_clk) disable iff (!i_nrst) o_hrdata[7:0] == 8'h00)
    else $error("read data low byte not zero");
  chk_wo_reads_zero:
  assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_hsel && i_htrans[1] && i_hready && !i_hwrite && i_haddr[3:2] != 2'h2)
    |=> o_hrdata == 32'h0000_0000) else $error("write-only register read nonzero");
  chk_sync_passive:
  assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    !o_frame_sync_pin_oe[0] |-> !o_frame_sync_pin[0]) else $error("sync driven when passive");
  chk_doe_passive:
  assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    !o_data_out_enable_pin_oe[0] |-> !o_data_out_enable_pin[0]) else $error("data enable high");
  chk_doe_needs_mode:
  assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    $rose(o_data_out_enable_pin[0]) |-> o_data_out_enable_pin_oe[0])
    else $error("data enable rose without drive");
  chk_sync_width:
  assert property (@(posedge i_link_clk) disable iff (!i_nrst) $rose(o_frame_sync_pin[0])
    |-> (o_frame_sync_pin[0] || !o_frame_sync_pin_oe[0])[*7] ##[1:8] !o_frame_sync_pin[0])
    else $error("sync pulse width wrong");
  chk_strobe_gap:
  assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    (o_input_load_strobe[0] && !ld_q && ld_seen) |-> ld_gap >= 8'h7C)
    else $error("load strobes too close");
  chk_frame_gap:
  assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    (o_frame_sync_pin[0] && !fs_q && fs_seen) |-> fs_gap >= 12'h3FC)
    else $error("frame shorter than 128 bits");
  cover property (@(posedge i_link_clk) $rose(o_frame_sync_pin[0]));
  cover property (@(posedge i_link_clk) $rose(o_data_out_enable_pin[0]));
  cover property (@(posedge i_core_clk) i_hsel && i_htrans[1] && i_haddr == 8'h08);
endmodule

bind stdm_top stdm_chk #(.NCH(NCH), .ADDR_W(ADDR_W)) u_chk (.i_core_clk(i_core_clk),
  .i_nrst(i_nrst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata), .i_link_clk(i_link_clk),
  .o_frame_sync_pin(o_frame_sync_pin), .o_frame_sync_pin_oe(o_frame_sync_pin_oe),
  .o_data_out_enable_pin(o_data_out_enable_pin),
  .o_data_out_enable_pin_oe(o_data_out_enable_pin_oe),
  .o_input_load_strobe(o_input_load_strobe));

// >>> verification/stdm_peer.sv
// Far-side model: another processor sharing the multiplexed serial bus.
// Assumes a free-running link clock; makes bit clocks, syncs and words.
`timescale 1ns/100ps
module stdm_peer #(
  parameter int NCH = 2 // Channels.
) (
  input wire logic i_link_clk, // Link clock.
  input wire logic [NCH-1:0] i_fs_oe, // Device drives sync when high.
  output logic [NCH-1:0] o_ick, // Input bit clocks, 8 link cycles.
  output logic [NCH-1:0] o_ock, // Output bit clocks, 10 link cycles.
  output logic [NCH-1:0] o_fs, // Sync offered by this party.
  output logic [NCH-1:0] o_rx_stb, // Word strobes.
  output logic [NCH*3-1:0] o_rx_addr, // Word addresses.
  output logic [NCH*8-1:0] o_rx_proto // Protocol bytes.
);
  logic [2:0] ip; // Input clock phase.
  logic [3:0] op; // Output clock phase.
  logic [6:0] bits; // Bit count of the offered frame.
  initial begin
    {ip, op, bits, o_ick, o_ock, o_fs, o_rx_stb, o_rx_addr, o_rx_proto} = '0;
  end
  // Bit clocks run free; a sync is offered only on channels left passive.
  always @(posedge i_link_clk) begin
    ip <= ip + 3'h1;
    op <= (op == 4'h9) ? 4'h0 : op + 4'h1;
    if (ip == 3'h7) begin
      bits <= bits + 7'h01;
    end
    o_ick <= {NCH{~ip[2]}};
    o_ock <= {NCH{op < 4'h5}};
    o_fs <= {NCH{bits == 7'h00}} & ~i_fs_oe;
  end
  // One word: data settle, strobe rises, then data go stale.
  task send(input int ch, input logic [2:0] a, input logic [7:0] p);
    @(posedge i_link_clk);
    o_rx_addr[ch*3+:3] <= a;
    o_rx_proto[ch*8+:8] <= p;
    repeat (5) @(posedge i_link_clk);
    o_rx_stb[ch] <= 1'b1;
    repeat (5) @(posedge i_link_clk);
    o_rx_addr[ch*3+:3] <= ~a; // Stale value is inverted, not kept.
    o_rx_proto[ch*8+:8] <= ~p;
    o_rx_stb[ch] <= 1'b0;
    repeat (60) @(posedge i_link_clk);
  endtask
endmodule

// >>> verification/tb.sv
// Testbench for the two-channel TDM slot, mask and protocol block.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module tb;
  localparam int NCH = 2;
  logic clk, lclk, nrst, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic [NCH-1:0] ick, ock, pfs, fs_out, fs_oe, doe, doe_oe, ild, old, rx_stb;
  logic [NCH*3-1:0] rx_addr;
  logic [NCH*8-1:0] rx_proto, tx_mask, tx_proto;
  wire [NCH-1:0] fs_wire = (fs_oe & fs_out) | (~fs_oe & pfs); // Shared sync wire.
  int failures, n_tests;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #1.7;
    forever #3 lclk = ~lclk;
  end
  stdm_top dut (.i_core_clk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hreadyout),
    .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .i_link_clk(lclk), .i_input_bit_clock(ick), .i_output_bit_clock(ock),
    .i_frame_sync_pin(fs_wire), .o_frame_sync_pin(fs_out), .o_frame_sync_pin_oe(fs_oe),
    .o_data_out_enable_pin(doe), .o_data_out_enable_pin_oe(doe_oe),
    .o_input_load_strobe(ild), .o_output_load_strobe(old), .i_rx_word_strobe(rx_stb),
    .i_rx_addr(rx_addr), .i_rx_protocol(rx_proto), .o_tx_addr_mask(tx_mask),
    .o_tx_protocol(tx_proto));
  stdm_peer #(.NCH(NCH)) peer (.i_link_clk(lclk), .i_fs_oe(fs_oe), .o_ick(ick),
    .o_ock(ock), .o_fs(pfs), .o_rx_stb(rx_stb), .o_rx_addr(rx_addr),
    .o_rx_proto(rx_proto));
  // Prints the verdict and ends the run.
  task complete_run();
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // A wait that ran out counts as a mismatch.
  task hang();
    failures++;
    $display("[ERR] %0t wait ran out", $time);
    complete_run();
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for an edge with ready high, bounded.
  task wait_rdy();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 20) hang();
  endtask
  // One single word transfer: address phase, then data phase.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    check(32'(hresp), 32'h0);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  // Counts one frame from sync rise to sync rise: length, enable-high, strobe rises.
  task frame(input int ch, output int len, output int on, output int st);
    logic pf, pi, po;
    bit go;
    int i;
    {len, on, st, go} = '0;
    {pf, pi, po} = 3'h7;
    for (i = 0; i < 9000; i++) begin
      @(posedge lclk);
      if (fs_out[ch] && !pf) begin
        if (go) break;
        go = 1'b1;
      end
      if (go) begin
        len++;
        on += int'(doe[ch]);
        st += int'(ild[ch] && !pi) + int'(old[ch] && !po);
      end
      {pf, pi, po} = {fs_out[ch], ild[ch], old[ch]};
    end
    if (i == 9000) hang();
  endtask
  // First two whole frames after a change are passed over; the third is checked.
  task meas(input int ch, input int el, input int eo, input int es);
    int len, on, st;
    repeat (2) frame(ch, len, on, st);
    check(32'(len), 32'(el));
    check(32'(on), 32'(eo));
    check(32'(st), 32'(es));
  endtask
  initial begin
    int ch;
    logic [7:0] b;
    {failures, n_tests} = '0;
    {nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h20, 32'h0);
    for (ch = 0; ch < NCH; ch++) begin
      b = 8'(ch * 16);
      wr(b + 8'h04, 32'h0000_8421);
      wr(b + 8'h08, 32'h0000_A5C3);
      rd(b, 32'h0);
      rd(b + 8'h04, 32'h0);
      rd(b + 8'h0C, 32'h0);
      rd(b + 8'h08, 32'h0);
      check({24'h0, tx_mask[ch*8+:8]}, 32'h21);
      check({24'h0, tx_proto[ch*8+:8]}, 32'hC3);
      wr(b + 8'h0C, 32'h6);
      wr(b, 32'h0000_01A5);
      meas(ch, 1024, 512, 16);
      check({30'h0, fs_oe[ch], doe_oe[ch]}, 32'h3);
      peer.send(ch, 3'h2, 8'h5A);
      rd(b + 8'h08, 32'h5A00);
      peer.send(ch, 3'h3, 8'h33);
      rd(b + 8'h08, 32'h5A00);
      peer.send(ch, 3'h7, 8'h77);
      rd(b + 8'h08, 32'h7700);
      wr(b + 8'h0C, 32'h0);
      wr(b, 32'h0000_0201);
      meas(ch, 2048, 0, 0);
      check({31'h0, doe_oe[ch]}, 32'h0);
      wr(b + 8'h0C, 32'h5);
      meas(ch, 2560, 0, 16);
      wr(b + 8'h0C, 32'h0);
      wr(b, 32'h0);
      peer.send(ch, 3'h3, 8'h3C);
      rd(b + 8'h08, 32'h3C00);
      check({31'h0, fs_oe[ch]}, 32'h0);
    end
    complete_run();
  end
endmodule
